// ---- core/eil_latch.sv ----
// Purpose: External interrupt request latch with mask, mode and acknowledge
// Assumes: Register port strobes are one cycle and never overlap
// Notes:   Pin level reaches latch logic two cycles late through the synchroniser
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "eil_regs.svh"

// What this block does
// - Falling edge on the pin sets the request latch in either mode.
// - Vector fetch acknowledge clears the request latch.
// - Writing one to acknowledge clears the latch; acknowledge reads zero.
// - Reset clears latch, acknowledge, mask and mode.
// - Mask set withholds the request from priority logic.
// - Mode bit: one edge plus level, zero edge only; read and write.
// - Edge-plus-level clears only after acknowledge and pin high, any order.
// - Edge-plus-level keeps request pending while the pin stays low.
// - Edge-only acknowledge clears the latch at once, whatever the pin.
// - A falling edge after a software acknowledge latches a new request.
// - Unmasked request taken makes the processor fetch the fixed vector pair.
// - Pending flag reads the request, independent of the mask.
// - In break with clear-enable zero, software acknowledge does nothing.
// - Clear-enable one lets break acknowledge clear; stays cleared afterwards.
// - Pin level is offered to the branch-on-pin instructions.
module eil_latch
    import eil_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire logic                   irq_pin_n,
    input  wire logic                   vec_fetch,
    input  wire logic                   break_state,
    input  wire logic [`EIL_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    output logic                        cpu_irq_req,
    output logic      [15:0]            vec_addr,
    output logic                        branch_pin_high,
    output logic                        branch_pin_low,
    output logic                        irq_out
);
    eil_pin_if pin ();

    logic                 latch_q;
    logic                 ack_seen_q;
    logic                 mask_q;
    eil_mode_t            mode_q;
    logic                 break_clear_enable_q;
    logic [`EIL_EVT_W-1:0] evt_q;
    logic [`EIL_EVT_W-1:0] emask_q;
    logic [7:0]           rdata_q;
    logic                 wr_ctrl;
    logic                 sw_ack;
    logic                 ack_any;
    logic                 pending;
    logic                 vec_taken;

    eil_pin_sync u_sync
    (
        .core_clk  (core_clk),
        .srst      (srst),
        .irq_pin_n (irq_pin_n),
        .pin       (pin)
    );

    // Decode of software acknowledge, gated in break state
    assign wr_ctrl = reg_wr && (reg_addr == `EIL_OFF_CTRL);
    assign sw_ack  = wr_ctrl && reg_wdata[`EIL_BIT_ACK]
                     && (!break_state || break_clear_enable_q);
    assign ack_any = sw_ack || vec_taken;

    // Vector fetch only counts when this unit's request is presented
    assign vec_taken = vec_fetch && cpu_irq_req;

    // Request latch; a new edge wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
            latch_q <= 1'b0;
        else if (pin.fall)
            latch_q <= 1'b1;
        else if (ack_any && mode_q == EIL_EDGE_ONLY)
            latch_q <= 1'b0;
        else if (mode_q == EIL_EDGE_LEVEL && (ack_any || ack_seen_q) && pin.level)
            latch_q <= 1'b0;
    end

    // Remembers an acknowledge that came while the pin was still low
    always_ff @(posedge core_clk)
    begin
        if (srst)
            ack_seen_q <= 1'b0;
        else if (pin.fall || !latch_q)
            ack_seen_q <= 1'b0;
        else if (ack_any)
            ack_seen_q <= 1'b1;
    end

    // In level mode a low pin holds the request on, even after acknowledge
    assign pending = latch_q
                     || (mode_q == EIL_EDGE_LEVEL && !pin.level);

    assign cpu_irq_req = pending && !mask_q;

    // Fixed vector pair; the low-address location is the high byte
    assign vec_addr = vec_fetch ? `EIL_VEC_HI : `EIL_VEC_LO;

    // Pin level for branch instructions
    assign branch_pin_high = pin.level;
    assign branch_pin_low  = !pin.level;

    // Mask and mode; acknowledge is not stored so it always reads zero
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            mask_q <= 1'(`EIL_CTRL_RST >> `EIL_BIT_MASK);
            mode_q <= EIL_EDGE_ONLY;
        end
        else if (wr_ctrl)
        begin
            mask_q <= reg_wdata[`EIL_BIT_MASK];
            mode_q <= eil_mode_t'(reg_wdata[`EIL_BIT_MODE]);
        end
    end

    // Break clear-enable, zero by default
    always_ff @(posedge core_clk)
    begin
        if (srst)
            break_clear_enable_q <= 1'(`EIL_BRK_RST >> `EIL_BIT_BREAK_CLEAR_ENABLE);
        else if (reg_wr && reg_addr == `EIL_OFF_BRK)
            break_clear_enable_q <= reg_wdata[`EIL_BIT_BREAK_CLEAR_ENABLE];
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge core_clk)
    begin
        if (srst)
            evt_q <= 2'h0;
        else
        begin
            for (int i = 0; i < `EIL_EVT_W; i++)
            begin
                if ((i == `EIL_EVT_EDGE && pin.fall) || (i == `EIL_EVT_VEC && vec_taken))
                    evt_q[i] <= 1'b1;
                else if (reg_wr && reg_addr == `EIL_OFF_EVT && reg_wdata[i])
                    evt_q[i] <= 1'b0;
            end
        end
    end

    // Event mask register, one enables the event onto irq_out
    always_ff @(posedge core_clk)
    begin
        if (srst)
            emask_q <= 2'h0;
        else if (reg_wr && reg_addr == `EIL_OFF_EMASK)
            emask_q <= reg_wdata[`EIL_EVT_W-1:0];
    end

    assign irq_out = |(evt_q & emask_q);

    // Read data one cycle after the strobe, zero when idle or unmapped
    always_ff @(posedge core_clk)
    begin
        if (srst || !reg_rd)
            rdata_q <= 8'h00;
        else
        begin
            case (reg_addr)
                `EIL_OFF_CTRL:
                    rdata_q <= {3'h0, pin.level, pending, 1'b0, mask_q, mode_q};
                `EIL_OFF_BRK:
                    rdata_q <= {7'h00, break_clear_enable_q};
                `EIL_OFF_EVT:
                    rdata_q <= {6'h00, evt_q};
                `EIL_OFF_EMASK:
                    rdata_q <= {6'h00, emask_q};
                default:
                    rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_q;
endmodule : eil_latch

// ---- core/eil_regs.svh ----
// Purpose: Offsets, field positions, reset values and vector addresses of the interrupt latch
// Assumes: Eight-bit register port, one word per register
// Notes:   Offsets are local choices
`ifndef EIL_REGS_SVH
`define EIL_REGS_SVH

`define EIL_ADDR_W          4
`define EIL_OFF_CTRL        4'h0
`define EIL_OFF_BRK         4'h1
`define EIL_OFF_EVT         4'h2
`define EIL_OFF_EMASK       4'h3

// Status and control fields
`define EIL_BIT_MODE        0
`define EIL_BIT_MASK        1
`define EIL_BIT_ACK         2
`define EIL_BIT_PEND        3
`define EIL_BIT_PIN         4

// Break control field
`define EIL_BIT_BREAK_CLEAR_ENABLE        0

// Event status fields
`define EIL_EVT_EDGE        0
`define EIL_EVT_VEC         1
`define EIL_EVT_W           2

`define EIL_CTRL_RST        8'h00
`define EIL_BRK_RST         8'h00
`define EIL_VEC_HI          16'hFFFA
`define EIL_VEC_LO          16'hFFFB

`endif

// ---- core/eil_pkg.sv ----
// Purpose: Types shared by the interrupt latch files
// Assumes: Constants live in eil_regs.svh
// Notes:   Sensitivity mode encoding follows the control bit
package eil_pkg;

    typedef enum logic
    {
        EIL_EDGE_ONLY  = 1'b0,
        EIL_EDGE_LEVEL = 1'b1
    } eil_mode_t;

endpackage : eil_pkg

// ---- core/eil_pin_if.sv ----
// Purpose: Carries synchronised pin level and falling edge between modules
// Assumes: Single clock domain
// Notes:   Producer is the synchroniser, consumer the latch logic
`timescale 1ns/10ps

interface eil_pin_if;
    logic level;
    logic fall;

    modport src
    (
        output level,
        output fall
    );

    modport dst
    (
        input  level,
        input  fall
    );
endinterface : eil_pin_if

// ---- core/eil_pin_sync.sv ----
// Purpose: Two-stage synchroniser and falling-edge detector for the request pin
// Assumes: Pin is asynchronous to core_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps

module eil_pin_sync
(
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic irq_pin_n,
    eil_pin_if.src    pin
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Reset to high: idle pin is pulled up, so no false edge after reset
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end
        else
        begin
            s1_q <= irq_pin_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Edge from two synchronised samples
    assign pin.level = s2_q;
    assign pin.fall  = s3_q & ~s2_q;
endmodule : eil_pin_sync

// ---- sim/eil_latch_assertions.sv ----
// Purpose: Port-level checks of the interrupt latch
// Assumes: Mask, mode and clear-enable shadowed from writes
// Notes:   Pin reaches the latch two cycles late
`timescale 1ns/10ps
`include "eil_regs.svh"

module eil_latch_assertions
(
    input wire logic                   core_clk,
    input wire logic                   srst,
    input wire logic                   irq_pin_n,
    input wire logic                   vec_fetch,
    input wire logic                   break_state,
    input wire logic [`EIL_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   cpu_irq_req,
    input wire logic [15:0]            vec_addr,
    input wire logic                   branch_pin_high,
    input wire logic                   branch_pin_low
);
    logic mask_h, mode_h, break_clear_enable_h;
    wire  ctl_wr = reg_wr && reg_addr == `EIL_OFF_CTRL;
    wire  ack_wr = ctl_wr && reg_wdata[2:0] == 3'h4;

    // Shadow bits; the request output cannot be judged without them
    always_ff @(posedge core_clk)
        if (srst)
            {mask_h, mode_h, break_clear_enable_h} <= 3'h0;
        else if (reg_wr)
        begin
            if (reg_addr == `EIL_OFF_CTRL)
                {mask_h, mode_h} <= reg_wdata[1:0];
            if (reg_addr == `EIL_OFF_BRK)
                break_clear_enable_h <= reg_wdata[0];
        end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_edge_sets: assert property ($fell(branch_pin_high) && !mask_h && !ctl_wr |=> cpu_irq_req)
        else $error("edge missed");
    a_mask_holds: assert property (mask_h |-> !cpu_irq_req)
        else $error("masked request shown");
    a_ack_clears: assert property (ack_wr && !mode_h && !break_state && !$fell(branch_pin_high)
        |=> !cpu_irq_req) else $error("ack kept request");
    a_vec_clears: assert property (vec_fetch && cpu_irq_req && !mode_h && !ctl_wr
        && !$fell(branch_pin_high) |=> !cpu_irq_req) else $error("fetch kept request");
    a_brk_protect: assert property (break_state && !break_clear_enable_h && ack_wr && !vec_fetch
        && cpu_irq_req |=> cpu_irq_req) else $error("break ack cleared");
    a_level_holds: assert property (mode_h && !branch_pin_high && cpu_irq_req && !ctl_wr
        |=> cpu_irq_req) else $error("level request dropped");
    a_vec_pick: assert property (vec_addr == (vec_fetch ? 16'hFFFA : 16'hFFFB))
        else $error("bad vector address");
    a_pin_low_seen: assert property ((!irq_pin_n)[*3] |-> branch_pin_low && !branch_pin_high)
        else $error("pin low not seen");
endmodule : eil_latch_assertions

bind eil_latch eil_latch_assertions u_chk (.core_clk, .srst, .irq_pin_n, .vec_fetch, .break_state,
    .reg_addr, .reg_wdata, .reg_wr, .cpu_irq_req, .vec_addr, .branch_pin_high, .branch_pin_low);

// ---- sim/eil_pin_drv.sv ----
// Purpose: Circuit driving the request pin
// Assumes: Pin has a pull-up, so released reads high
// Notes:   Moves 3 ns after a clock edge, never on it
`timescale 1ns/10ps

module eil_pin_drv
(
    input  wire logic hold_low,
    output logic      irq_pin_n
);
    // Idle high through the pull-up
    initial irq_pin_n = 1'b1;
    always @(hold_low) irq_pin_n <= #3 !hold_low;
endmodule : eil_pin_drv

// ---- sim/external_irq_latch_test.sv ----
// Purpose: Self-checking bench for the interrupt latch
// Assumes: Read data stand only in the cycle after the strobe
// Notes:   Expected words come from an integer model
`timescale 1ns/10ps
`include "eil_regs.svh"

module external_irq_latch_test;
    localparam logic [3:0] ctl = `EIL_OFF_CTRL;
    logic        core_clk = 1'b0, srst = 1'b1, vec_fetch = 1'b0, break_state = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, hold_low = 1'b0;
    logic        irq_pin_n, cpu_irq_req, branch_pin_high, branch_pin_low, irq_out;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic [15:0] vec_addr;
    logic [31:0] lfsr_q = 32'h6416;
    int          miscompares = 0, tests_run = 0, pend = 0, mask = 0, mode = 0, pin = 1;

    // Core clock, 8 ns period
    always #4 core_clk = ~core_clk;

    eil_pin_drv drv (.hold_low, .irq_pin_n);
    eil_latch DUT (.core_clk, .srst, .irq_pin_n, .vec_fetch, .break_state, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .cpu_irq_req, .vec_addr, .branch_pin_high, .branch_pin_low,
        .irq_out);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Model view of the status and control word
    function automatic logic [7:0] ctrl_exp();
        return {3'h0, pin[0], pend[0], 1'b0, mask[0], mode[0]};
    endfunction : ctrl_exp
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // Random settle time past the synchroniser
    task automatic pin_set(input logic low);
        @(posedge core_clk);
        hold_low <= low;
        pin = !low;
        lfsr_q = lfsr(lfsr_q);
        repeat (5 + lfsr_q[1:0]) @(posedge core_clk);
    endtask : pin_set
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // Hang guard
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end

    // Edge, level, break, event and reset cases in turn
    initial
    begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        rd(ctl, ctrl_exp());
        rd(`EIL_OFF_BRK, 8'h00);
        rd(4'hF, 8'h00);
        pin_set(1);
        pend = 1;
        rd(ctl, ctrl_exp());
        chk({branch_pin_high, branch_pin_low}, 2'b01);
        wr(ctl, 8'h02);
        mask = 1;
        rd(ctl, ctrl_exp());
        chk(cpu_irq_req, 1'b0);
        wr(ctl, 8'h04);
        {mask, pend} = 0;
        rd(ctl, ctrl_exp());
        pin_set(0);
        pin_set(1);
        pend = 1;
        rd(ctl, ctrl_exp());
        @(posedge core_clk);
        vec_fetch <= 1'b1;
        #1 chk(vec_addr, 16'hFFFA);
        @(posedge core_clk);
        vec_fetch <= 1'b0;
        pend = 0;
        rd(ctl, ctrl_exp());
        pin_set(0);
        wr(ctl, 8'h01);
        mode = 1;
        pin_set(1);
        pend = 1;
        wr(ctl, 8'h07);
        mask = 1;
        rd(ctl, ctrl_exp());
        pin_set(0);
        pend = 0;
        rd(ctl, ctrl_exp());
        wr(ctl, 8'h01);
        mask = 0;
        pin_set(1);
        pend = 1;
        pin_set(0);
        rd(ctl, ctrl_exp());
        wr(ctl, 8'h05);
        pend = 0;
        rd(ctl, ctrl_exp());
        wr(ctl, 8'h00);
        mode = 0;
        break_state <= 1'b1;
        pin_set(1);
        pend = 1;
        wr(ctl, 8'h04);
        rd(ctl, ctrl_exp());
        wr(`EIL_OFF_BRK, 8'h01);
        wr(ctl, 8'h04);
        pend = 0;
        break_state <= 1'b0;
        rd(ctl, ctrl_exp());
        pin_set(0);
        wr(`EIL_OFF_EVT, 8'h03);
        wr(`EIL_OFF_EMASK, 8'h01);
        pin_set(1);
        pend = 1;
        #1 chk(irq_out, 1'b1);
        rd(`EIL_OFF_EVT, 8'h01);
        wr(`EIL_OFF_EMASK, 8'h00);
        #1 chk(irq_out, 1'b0);
        pin_set(0);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        pend = 0;
        rd(ctl, ctrl_exp());
        rd(`EIL_OFF_BRK, 8'h00);
        conclude();
    end
endmodule : external_irq_latch_test
